// ### logic/compare_match_output.sv
/*
  Compare unit: compares a 16-bit compare value with one of two timer
  counts and, on a match, sets the match flag and acts on the output pin or
  issues a special event trigger that resets the timer and may start a
  conversion.
  Assumes timers counting synchronously to clk_sys and software that
  drives the configuration ports as levels.
*/
// Functional notes
// [RL1] The compare value is checked every cycle against the selected timer count while compare mode is on.
// [RL2] A match drives the pin high, low, toggles it or leaves it following the port latch, by mode.
// [RL3] The match flag is set in the same cycle the pin action takes effect.
// [RL4] Writing zero to the control register forces the compare output latch low, not the port latch.
// [RL5] The selected timer must run in timer or synchronized counter mode for reliable matches.
// [RL6] In soft interrupt mode a match sets only the flag and leaves the pin alone.
// [RL7] In special event mode a match produces an internal one-cycle trigger pulse.
// [RL8] The trigger resets the count of the timer that is the current time base.
// [RL9] The trigger starts a conversion only if the converter was enabled beforehand.
// [RL10] Software must clear the pin direction bit so the pin acts as an output.
// [RL11] A match acts once, on the first cycle of equality, not while the count holds.
`timescale 1ns/1ps

module compare_match_output (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // configuration
  input wire logic [3:0] compareModeSelect,
  input wire logic controlWriteZero,
  input wire logic timeBaseSel,
  input wire logic [15:0] compareValue,
  // timers
  input wire logic [15:0] timerACount,
  input wire logic [15:0] timerBCount,
  output logic timerAReset,
  output logic timerBReset,
  // port and pin
  input wire logic portLatch,
  input wire logic pinDirection,
  output logic compareOutputPin,
  output logic compareOutputEn,
  // flag
  input wire logic flagClear,
  output logic compareMatchFlag,
  // converter
  input wire logic adcEnabled,
  output logic specialEventTrigger,
  output logic adcStart
);

  // ===========================================================
  // declarations
  match_if mif ();
  logic modeActive;
  logic usesLatch;
  logic [15:0] selCount;
  compare_pkg::pin_action_t action;
  logic compareLatch_reg;
  logic compareLatch_next;
  logic pinOut_reg;
  logic pinEn_reg;
  logic flag_reg;
  logic trigger_reg;
  logic resetA_reg;
  logic resetB_reg;
  logic adcStart_reg;

  // ===========================================================
  // time base selection and mode decode
  assign selCount = (timeBaseSel == compare_pkg::TIME_BASE_B) ? timerBCount : timerACount;

  // compare is on for toggle and the four match modes
  always_comb begin
    modeActive = 1'b0;
    usesLatch = 1'b0;
    action = compare_pkg::ACT_NONE;
    unique case (compareModeSelect)
      compare_pkg::MODE_TOGGLE: begin
        modeActive = 1'b1;
        usesLatch = 1'b1;
        action = compare_pkg::ACT_FLIP;
      end
      compare_pkg::MODE_SET_HIGH: begin
        modeActive = 1'b1;
        usesLatch = 1'b1;
        action = compare_pkg::ACT_HIGH;
      end
      compare_pkg::MODE_SET_LOW: begin
        modeActive = 1'b1;
        usesLatch = 1'b1;
        action = compare_pkg::ACT_LOW;
      end
      compare_pkg::MODE_SOFT_INT, compare_pkg::MODE_SPECIAL: begin
        modeActive = 1'b1;
      end
      default: begin
        modeActive = 1'b0;
      end
    endcase
  end

  // ===========================================================
  // equality detector
  assign mif.selCount = selCount; // [RL1]
  assign mif.compareValue = compareValue;
  assign mif.active = modeActive; // [RL1]

  match_detect u_detect (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mif(mif.detector)
  );

  // ===========================================================
  // compare output latch
  always_comb begin
    compareLatch_next = compareLatch_reg;
    if (controlWriteZero) begin
      compareLatch_next = compare_pkg::LATCH_RESET; // [RL4]
    end else if (mif.hit) begin // [RL11]
      unique case (action)
        compare_pkg::ACT_HIGH: compareLatch_next = 1'b1; // [RL2]
        compare_pkg::ACT_LOW: compareLatch_next = 1'b0; // [RL2]
        compare_pkg::ACT_FLIP: compareLatch_next = !compareLatch_reg; // [RL2]
        compare_pkg::ACT_NONE: compareLatch_next = compareLatch_reg; // [RL6]
      endcase
    end
  end

  // latch register, only this unit's, never the port latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compareLatch_reg <= compare_pkg::LATCH_RESET;
    end else begin
      compareLatch_reg <= compareLatch_next;
    end
  end

  // ===========================================================
  // pin drive: latch in pin modes except during a zero write, port latch otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_reg <= 1'b0;
      pinEn_reg <= 1'b0;
    end else begin
      pinOut_reg <= (usesLatch && !controlWriteZero) ? compareLatch_next : portLatch; // [RL2] [RL6]
      pinEn_reg <= !pinDirection; // [RL10]
    end
  end

  // ===========================================================
  // match flag, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= compare_pkg::FLAG_RESET;
    end else if (mif.hit) begin
      flag_reg <= 1'b1; // [RL3]
    end else if (flagClear) begin
      flag_reg <= 1'b0;
    end
  end

  // ===========================================================
  // special event trigger, timer reset and conversion start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trigger_reg <= 1'b0;
      resetA_reg <= 1'b0;
      resetB_reg <= 1'b0;
      adcStart_reg <= 1'b0;
    end else begin
      trigger_reg <= mif.hit && (compareModeSelect == compare_pkg::MODE_SPECIAL); // [RL7]
      resetA_reg <= mif.hit && (compareModeSelect == compare_pkg::MODE_SPECIAL)
        && (timeBaseSel == compare_pkg::TIME_BASE_A); // [RL8]
      resetB_reg <= mif.hit && (compareModeSelect == compare_pkg::MODE_SPECIAL)
        && (timeBaseSel == compare_pkg::TIME_BASE_B); // [RL8]
      adcStart_reg <= mif.hit && (compareModeSelect == compare_pkg::MODE_SPECIAL)
        && adcEnabled; // [RL9]
    end
  end

  // ===========================================================
  // outputs
  assign compareOutputPin = pinOut_reg;
  assign compareOutputEn = pinEn_reg;
  assign compareMatchFlag = flag_reg;
  assign specialEventTrigger = trigger_reg;
  assign timerAReset = resetA_reg;
  assign timerBReset = resetB_reg;
  assign adcStart = adcStart_reg;

  // ===========================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_hit_in(logic [3:0] m);
    mif.hit && (compareModeSelect == m) && !controlWriteZero;
  endsequence

  sequence s_one_pulse;
    specialEventTrigger ##1 !specialEventTrigger;
  endsequence

  property p_match_cause;
    mif.hit |-> modeActive && (selCount == compareValue);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("hit without equality"); // [RL1]

  property p_drive_high;
    s_hit_in(compare_pkg::MODE_SET_HIGH) |=> compareOutputPin && compareLatch_reg;
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("pin not driven high"); // [RL2]

  property p_drive_low;
    s_hit_in(compare_pkg::MODE_SET_LOW) |=> !compareOutputPin;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin not driven low"); // [RL2]

  property p_toggle;
    s_hit_in(compare_pkg::MODE_TOGGLE) |=> compareLatch_reg != $past(compareLatch_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin not toggled"); // [RL2]

  property p_flag_with_pin;
    mif.hit |=> compareMatchFlag;
  endproperty
  a_flag_with_pin: assert property (p_flag_with_pin) else $error("flag late"); // [RL3]

  property p_zero_write;
    controlWriteZero |=> !compareLatch_reg;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("latch not forced low"); // [RL4]

  property p_soft_int;
    s_hit_in(compare_pkg::MODE_SOFT_INT) |=> compareOutputPin == $past(portLatch) && !specialEventTrigger;
  endproperty
  a_soft_int: assert property (p_soft_int) else $error("soft mode touched pin"); // [RL6]

  property p_trigger;
    mif.hit && (compareModeSelect == compare_pkg::MODE_SPECIAL) |=> s_one_pulse;
  endproperty
  a_trigger: assert property (p_trigger) else $error("no trigger pulse"); // [RL7]

  property p_timer_reset;
    specialEventTrigger |-> (timerAReset != timerBReset) && (timerBReset == $past(timeBaseSel));
  endproperty
  a_timer_reset: assert property (p_timer_reset) else $error("wrong timer reset"); // [RL8]

  property p_adc_start;
    adcStart |-> specialEventTrigger && $past(adcEnabled);
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("conversion start unqualified"); // [RL9]

  property p_once;
    mif.hit ##1 ($stable(selCount) && $stable(compareValue)) |-> !mif.hit;
  endproperty
  a_once: assert property (p_once) else $error("repeated hit"); // [RL11]

endmodule

// ### logic/compare_pkg.sv
/*
  Shared constants for the compare match unit: data widths, compare mode
  codes and reset values.
  Assumes nothing beyond a SystemVerilog compiler; it holds no logic.
*/
package compare_pkg;

  // ===========================================================
  // widths
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned MODE_W = 4;

  // ===========================================================
  // compare mode select codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW = 4'h9;
  localparam logic [3:0] MODE_SOFT_INT = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;

  // ===========================================================
  // time base select codes
  localparam logic TIME_BASE_A = 1'b0;
  localparam logic TIME_BASE_B = 1'b1;

  // ===========================================================
  // reset values
  localparam logic LATCH_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ===========================================================
  // action taken on the pin latch at a match
  typedef enum logic [3:0] {
    ACT_NONE = 4'b0001,
    ACT_HIGH = 4'b0010,
    ACT_LOW = 4'b0100,
    ACT_FLIP = 4'b1000
  } pin_action_t;

endpackage

// ### logic/match_detect.sv
/*
  Equality detector: flags the first cycle on which the selected timer
  count equals the compare value while compare mode is active.
  Assumes the count is synchronous to clk_sys.
*/
`timescale 1ns/1ps

module match_detect (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // operands and hit pulse
  match_if.detector mif
);

  logic equalNow;
  logic equalSeen_reg;

  // ===========================================================
  // continuous comparison
  assign equalNow = mif.active && (mif.selCount == mif.compareValue);

  // remembers equality from last cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      equalSeen_reg <= 1'b0;
    end else begin
      equalSeen_reg <= equalNow;
    end
  end

  // hit once per equality run, not while the count stands still
  assign mif.hit = equalNow && !equalSeen_reg;

endmodule

// ### logic/match_if.sv
/*
  Interface between the compare unit and its equality detector.
  Assumes both ends share clk_sys; it carries no clock of its own.
*/
`timescale 1ns/1ps

interface match_if;

  // ===========================================================
  // compared operands and qualifier
  logic [15:0] selCount;
  logic [15:0] compareValue;
  logic active;

  // ===========================================================
  // one-cycle pulse on the first cycle of equality
  logic hit;

  modport detector (
    input selCount,
    input compareValue,
    input active,
    output hit
  );

  modport user (
    output selCount,
    output compareValue,
    output active,
    input hit
  );

endinterface

// ### tb/compare_match_output_test.sv
/*
  Self-checking bench for the compare unit with a timer partner model.
  Assumes the unit answers a match one clock after the equal cycle.
*/
`timescale 1ns/1ps
module compare_match_output_test;
  // ===========================================================
  // stimulus and observed signals
  logic clk_sys, rst_n, controlWriteZero, timeBaseSel, portLatch, pinDirection;
  logic flagClear, adcEnabled, run, timerAReset, timerBReset, pin, pinEn, flag, trig, adcStart;
  logic [3:0] mode;
  logic [1:0] load;
  logic [15:0] compareValue, loadValue, timerACount, timerBCount;
  logic [27:0] tModes = 28'hBBA_9228;
  logic [6:0] tBase = 7'h4A;
  logic [6:0] tPin = 7'h75;
  logic [6:0] tAdc = 7'h20;
  localparam logic [15:0] VAL = 16'h1234;
  int nErrors, checked, k;

  compare_match_output compare_match_output_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .compareModeSelect(mode), .controlWriteZero(controlWriteZero), .timeBaseSel(timeBaseSel),
    .compareValue(compareValue), .timerACount(timerACount), .timerBCount(timerBCount),
    .timerAReset(timerAReset), .timerBReset(timerBReset), .portLatch(portLatch),
    .pinDirection(pinDirection), .compareOutputPin(pin), .compareOutputEn(pinEn),
    .flagClear(flagClear), .compareMatchFlag(flag), .adcEnabled(adcEnabled),
    .specialEventTrigger(trig), .adcStart(adcStart));
  timer_model timer_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .run(run), .load(load),
    .loadValue(loadValue), .timerAReset(timerAReset), .timerBReset(timerBReset),
    .timerACount(timerACount), .timerBCount(timerBCount));

  // ===========================================================
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // counts and verdict
  task results;
    $display("checks %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // zero both timers, then step the selected one onto the compare value
  task hit(input logic [3:0] m, input logic b, input logic adc);
    @(posedge clk_sys);
    load <= 2'b11;
    loadValue <= 16'h0000;
    flagClear <= 1'b1;
    @(posedge clk_sys);
    flagClear <= 1'b0;
    load <= 2'b01 << b;
    loadValue <= VAL;
    mode <= m;
    timeBaseSel <= b;
    adcEnabled <= adc;
    @(posedge clk_sys);
    load <= 2'b00;
    @(posedge clk_sys);
    #1;
  endtask

  // bounded wait for a trigger while the timer runs
  task waitTrig;
    k = 0;
    while (trig !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (trig !== 1'b1) begin
      nErrors++;
      results();
    end
    @(posedge clk_sys);
    #1;
    check(timerACount, 16'h0000);
  endtask

  // ===========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    mode = 4'h0;
    controlWriteZero = 1'b0;
    timeBaseSel = 1'b0;
    compareValue = VAL;
    portLatch = 1'b1;
    pinDirection = 1'b1;
    flagClear = 1'b0;
    adcEnabled = 1'b0;
    run = 1'b0;
    load = 2'b00;
    loadValue = 16'h0000;
    nErrors = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(16'(pinEn), 16'h0000);
    @(posedge clk_sys);
    pinDirection <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(16'(pinEn), 16'h0001);
    // every active mode, both time bases
    for (int i = 0; i < 7; i++) begin
      hit(tModes[4*i +: 4], tBase[i], tAdc[i]);
      check(16'(flag), 16'h0001);
      check(16'(pin), 16'(tPin[i]));
      check(16'(trig), 16'(tModes[4*i +: 4] == 4'hB));
      check({14'h0000, timerBReset, timerAReset}, 16'(trig) << tBase[i]);
      check(16'(adcStart), 16'(trig & tAdc[i]));
      @(posedge clk_sys);
      flagClear <= 1'b1;
      @(posedge clk_sys);
      flagClear <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      check({14'h0000, trig, flag}, 16'h0000);
      check(16'(pin), 16'(tPin[i]));
    end
    // zero write forces the compare latch low, port latch kept
    hit(4'h8, 1'b0, 1'b0);
    @(posedge clk_sys);
    mode <= 4'h0;
    controlWriteZero <= 1'b1;
    load <= 2'b11;
    loadValue <= 16'h0000;
    @(posedge clk_sys);
    controlWriteZero <= 1'b0;
    load <= 2'b00;
    @(posedge clk_sys);
    #1;
    check(16'(pin), 16'h0001);
    @(posedge clk_sys);
    mode <= 4'h2;
    repeat (2) @(posedge clk_sys);
    #1;
    check(16'(pin), 16'h0000);
    // running timer: special event resets it two clocks after the count reaches the compare value
    @(posedge clk_sys);
    mode <= 4'hB;
    compareValue <= 16'h0010;
    run <= 1'b1;
    waitTrig();
    waitTrig();
    run <= 1'b0;
    results();
  end
endmodule

// ### tb/timer_model.sv
/*
  Two-timer partner model: synchronous counters that the bench can load
  and run, and that the unit can reset.
  Assumes the unit shares clk_sys and rst_n.
*/
`timescale 1ns/1ps
module timer_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bench control
  input wire logic run,
  input wire logic [1:0] load,
  input wire logic [15:0] loadValue,
  // unit side
  input wire logic timerAReset,
  input wire logic timerBReset,
  output logic [15:0] timerACount,
  output logic [15:0] timerBCount
);
  // ===========================================================
  // synchronous counters, trigger reset beats load and count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timerACount <= 16'h0000;
      timerBCount <= 16'h0000;
    end else begin
      if (timerAReset) timerACount <= 16'h0000;
      else if (load[0]) timerACount <= loadValue;
      else if (run) timerACount <= timerACount + 16'h0001;
      if (timerBReset) timerBCount <= 16'h0000;
      else if (load[1]) timerBCount <= loadValue;
      else if (run) timerBCount <= timerBCount + 16'h0001;
    end
  end
endmodule
